// File: core/dac_trim_ctrl.sv
// trim, range, output clamp, io port and ground offset logic of a dual dac
`timescale 1ns/1ps
`include "dac_trim_params.svh"

module dac_trim_ctrl (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rstn_i,
    input  wire logic                      ce_i,
    input  wire dac_trim_pkg::reg_req_t    reg_req_i,
    output logic [`DTC_DATA_W-1:0]         reg_rdata_o,
    input  wire logic                      supply_ok_i,
    input  wire logic                      reset_request_input_n_i,
    output logic                           supply_monitor_output_o,
    output logic [1:0]                     amp_connect_gate_o,
    output logic [1:0]                     output_clamp_gate_o,
    output logic [1:0][`DTC_CODE_W-1:0]    channel_code_o,
    output logic [1:0][`DTC_RANGE_W-1:0]   range_sel_o,
    output logic                           local_gnd_adjust_en_o,
    input  wire logic [1:0][`DTC_GND_W-1:0] gnd_diff_i,
    input  wire logic                      io_pin_zero_i,
    output logic                           io_pin_zero_o,
    output logic                           io_pin_zero_oe_n_o,
    input  wire logic                      io_pin_one_i,
    output logic                           io_pin_one_o,
    output logic                           io_pin_one_oe_n_o
);
    dac_trim_pkg::trim_state_t st_r;
    dac_trim_pkg::trim_state_t st_nxt;
    logic [1:0] pin_in;
    logic       hold_cond;
    logic       wr_data;

    // trimmed code in eighths of an lsb
    function automatic logic [`DTC_CODE_W-1:0] trim_code(
        input logic [`DTC_DATA_W-1:0] data,
        input logic [`DTC_OFFS_W-1:0] offs,
        input logic [`DTC_FINE_W-1:0] fine,
        input logic [`DTC_GND_W-1:0]  gnd,
        input logic                   gnd_en
    );
        logic signed [`DTC_CODE_W-1:0] base;
        logic signed [`DTC_CODE_W-1:0] offs_term;
        logic signed [`DTC_CODE_W-1:0] gnd_term;
        logic signed [`DTC_CODE_W+1:0] prod;
        logic signed [`DTC_CODE_W-1:0] gain_term;
        base      = `DTC_CODE_W'(signed'(data)) <<< `DTC_FRAC_BITS;
        offs_term = `DTC_CODE_W'(signed'(offs));
        gnd_term  = gnd_en ? `DTC_CODE_W'(signed'(gnd)) : '0;
        prod      = (`DTC_CODE_W+2)'(signed'(data)) * (`DTC_CODE_W+2)'(signed'(fine));
        gain_term = `DTC_CODE_W'(prod >>> `DTC_GAIN_SHIFT);
        trim_code = `DTC_CODE_W'(base + offs_term + gain_term + gnd_term);
    endfunction

    // pin level for inputs, driven value for outputs
    function automatic logic io_read(input logic dir, input logic val, input logic pin);
        io_read = dir ? val : pin;
    endfunction

    assign pin_in    = {io_pin_one_i, io_pin_zero_i};
    assign hold_cond = ~supply_ok_i | ~reset_request_input_n_i;
    assign wr_data   = reg_req_i.wr && (reg_req_i.addr == `DTC_ADDR_DATA_A ||
                                        reg_req_i.addr == `DTC_ADDR_DATA_B);

    always_comb begin
        st_nxt            = st_r;
        st_nxt.rdata      = '0;
        st_nxt.supply_mon = supply_ok_i;
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `DTC_ADDR_DATA_A,
                `DTC_ADDR_DATA_B: begin
                    st_nxt.data[reg_req_i.addr[0]] = reg_req_i.wdata;
                end
                `DTC_ADDR_RANGE_A,
                `DTC_ADDR_RANGE_B: begin
                    if (reg_req_i.wdata[`DTC_RANGE_W-1:0] != `DTC_RANGE_RSVD) begin
                        st_nxt.range[reg_req_i.addr[0]] =
                            reg_req_i.wdata[`DTC_RANGE_W-1:0];
                    end
                end
                `DTC_ADDR_FINE_A,
                `DTC_ADDR_FINE_B: begin
                    st_nxt.fine[reg_req_i.addr[0]] =
                        reg_req_i.wdata[`DTC_FINE_W-1:0];
                end
                `DTC_ADDR_OFFS_A,
                `DTC_ADDR_OFFS_B: begin
                    st_nxt.offs[reg_req_i.addr[0]] =
                        reg_req_i.wdata[`DTC_OFFS_W-1:0];
                end
                `DTC_ADDR_FUNC: begin
                    st_nxt.gnd_en    = reg_req_i.wdata[`DTC_FUNC_GND_EN];
                    st_nxt.io_dir[0] = reg_req_i.wdata[`DTC_FUNC_D0_DIR];
                    st_nxt.io_dir[1] = reg_req_i.wdata[`DTC_FUNC_D1_DIR];
                    if (reg_req_i.wdata[`DTC_FUNC_D0_DIR]) begin
                        st_nxt.io_val[0] = reg_req_i.wdata[`DTC_FUNC_D0_VAL];
                    end
                    if (reg_req_i.wdata[`DTC_FUNC_D1_DIR]) begin
                        st_nxt.io_val[1] = reg_req_i.wdata[`DTC_FUNC_D1_VAL];
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `DTC_ADDR_DATA_A,
                `DTC_ADDR_DATA_B: st_nxt.rdata = st_r.data[reg_req_i.addr[0]];
                `DTC_ADDR_RANGE_A,
                `DTC_ADDR_RANGE_B: begin
                    st_nxt.rdata[`DTC_RANGE_W-1:0] = st_r.range[reg_req_i.addr[0]];
                end
                `DTC_ADDR_FINE_A,
                `DTC_ADDR_FINE_B: begin
                    st_nxt.rdata[`DTC_FINE_W-1:0] = st_r.fine[reg_req_i.addr[0]];
                end
                `DTC_ADDR_OFFS_A,
                `DTC_ADDR_OFFS_B: begin
                    st_nxt.rdata[`DTC_OFFS_W-1:0] = st_r.offs[reg_req_i.addr[0]];
                end
                `DTC_ADDR_FUNC: begin
                    st_nxt.rdata[`DTC_FUNC_GND_EN] = st_r.gnd_en;
                    st_nxt.rdata[`DTC_FUNC_D0_DIR] = st_r.io_dir[0];
                    st_nxt.rdata[`DTC_FUNC_D1_DIR] = st_r.io_dir[1];
                    st_nxt.rdata[`DTC_FUNC_D0_VAL] =
                        io_read(st_r.io_dir[0], st_r.io_val[0], pin_in[0]);
                    st_nxt.rdata[`DTC_FUNC_D1_VAL] =
                        io_read(st_r.io_dir[1], st_r.io_val[1], pin_in[1]);
                end
                `DTC_ADDR_STATUS: begin
                    st_nxt.rdata[`DTC_STAT_MON]  = st_r.supply_mon;
                    st_nxt.rdata[`DTC_STAT_REQ]  = reset_request_input_n_i;
                    st_nxt.rdata[`DTC_STAT_WORD] = st_r.word_seen;
                    st_nxt.rdata[`DTC_STAT_OPEN] = (st_r.clamp == dac_trim_pkg::CLAMP_OPEN);
                end
                default: st_nxt.rdata = '0;
            endcase
        end
        // output clamp sequencing
        if (hold_cond) begin
            st_nxt.clamp     = dac_trim_pkg::CLAMP_HOLD;
            st_nxt.word_seen = 1'b0;
        end else begin
            if (wr_data) begin
                st_nxt.word_seen = 1'b1;
            end
            case (st_r.clamp)
                dac_trim_pkg::CLAMP_HOLD: begin
                    if (st_r.word_seen) begin
                        st_nxt.clamp = dac_trim_pkg::CLAMP_OPEN;
                    end
                end
                dac_trim_pkg::CLAMP_OPEN: st_nxt.clamp = dac_trim_pkg::CLAMP_OPEN;
                default: st_nxt.clamp = dac_trim_pkg::CLAMP_HOLD;
            endcase
        end
        for (int ch = 0; ch < 2; ch++) begin
            st_nxt.code[ch] = trim_code(st_r.data[ch], st_r.offs[ch], st_r.fine[ch],
                                        gnd_diff_i[ch], st_r.gnd_en);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r            <= '0;
            st_r.data       <= {2{`DTC_RST_DATA}};
            st_r.offs       <= {2{`DTC_RST_OFFS}};
            st_r.fine       <= {2{`DTC_RST_FINE}};
            st_r.range      <= {2{`DTC_RANGE_10V}};
            st_r.io_dir     <= `DTC_RST_DIR;
            st_r.io_val     <= `DTC_RST_VAL;
            st_r.gnd_en     <= 1'b0;
            st_r.clamp      <= dac_trim_pkg::CLAMP_HOLD;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o             = st_r.rdata;
    assign supply_monitor_output_o = st_r.supply_mon;
    assign amp_connect_gate_o      = {2{st_r.clamp == dac_trim_pkg::CLAMP_OPEN}};
    assign output_clamp_gate_o     = {2{st_r.clamp == dac_trim_pkg::CLAMP_HOLD}};
    assign channel_code_o          = st_r.code;
    assign range_sel_o             = st_r.range;
    assign local_gnd_adjust_en_o   = st_r.gnd_en;
    assign io_pin_zero_o           = st_r.io_val[0];
    assign io_pin_one_o            = st_r.io_val[1];
    assign io_pin_zero_oe_n_o      = ~st_r.io_dir[0];
    assign io_pin_one_oe_n_o       = ~st_r.io_dir[1];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    AST_BROWN_CLAMP:
        assert property (ce_i && !supply_ok_i |=> output_clamp_gate_o == 2'h3 &&
                         amp_connect_gate_o == 2'h0)
        else $error("clamp not engaged on low supply");

    AST_RESET_REQ_CLAMP:
        assert property (ce_i && !reset_request_input_n_i |=> output_clamp_gate_o == 2'h3 &&
                         amp_connect_gate_o == 2'h0)
        else $error("clamp not engaged on reset request");

    AST_RELEASE_CAUSE:
        assert property ($fell(output_clamp_gate_o[0]) |->
                         $past(supply_ok_i) && $past(reset_request_input_n_i) &&
                         $past(st_r.word_seen))
        else $error("clamp released without cause");

    AST_RELEASE_AFTER_WRITE:
        assert property (ce_i && wr_data && !hold_cond ##1 ce_i && !hold_cond |=>
                         output_clamp_gate_o == 2'h0 && amp_connect_gate_o == 2'h3)
        else $error("clamp not released after data write");

    AST_SUPPLY_MON:
        assert property (ce_i |=> supply_monitor_output_o == $past(supply_ok_i))
        else $error("supply monitor output wrong");

    AST_ZERO_TRIM_CODE:
        assert property (ce_i && st_r.offs[0] == '0 && st_r.fine[0] == '0 && !st_r.gnd_en
                         |=> channel_code_o[0] ==
                         `DTC_CODE_W'(signed'($past(st_r.data[0])) <<< `DTC_FRAC_BITS))
        else $error("untrimmed code does not follow data");

    AST_OFFSET_STEP:
        assert property (ce_i && st_r.fine[1] == '0 && !st_r.gnd_en |=>
                         `DTC_CODE_W'(channel_code_o[1] -
                         (`DTC_CODE_W'(signed'($past(st_r.data[1]))) <<< `DTC_FRAC_BITS)) ==
                         `DTC_CODE_W'(signed'($past(st_r.offs[1]))))
        else $error("offset trim not applied in eighth lsb steps");

    AST_GND_CORRECT:
        assert property (ce_i && st_r.gnd_en && st_r.fine[0] == '0 && st_r.offs[0] == '0 |=>
                         `DTC_CODE_W'(channel_code_o[0] -
                         (`DTC_CODE_W'(signed'($past(st_r.data[0]))) <<< `DTC_FRAC_BITS)) ==
                         `DTC_CODE_W'(signed'($past(gnd_diff_i[0]))))
        else $error("ground offset correction not applied");

    AST_GND_EN_WRITE_ONLY:
        assert property ($changed(local_gnd_adjust_en_o) |->
                         $past(ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_FUNC))
        else $error("ground offset enable changed without write");

    AST_INPUT_READBACK:
        assert property (ce_i && reg_req_i.rd && reg_req_i.addr == `DTC_ADDR_FUNC &&
                         io_pin_zero_oe_n_o |=>
                         reg_rdata_o[`DTC_FUNC_D0_VAL] == $past(io_pin_zero_i))
        else $error("input pin level not read back");

    AST_INPUT_WRITE_IGNORED:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_FUNC &&
                         !reg_req_i.wdata[`DTC_FUNC_D1_DIR] |=>
                         io_pin_one_oe_n_o && $stable(io_pin_one_o))
        else $error("input pin value changed by write");

    AST_GATES_OPPOSED:
        assert property (amp_connect_gate_o == ~output_clamp_gate_o)
        else $error("amplifier gate and clamp gate not opposed");

    AST_HOLD_BLOCKS_ARM:
        assert property (ce_i && wr_data && hold_cond |=> !st_r.word_seen &&
                         output_clamp_gate_o == 2'h3)
        else $error("data write armed release during hold");

    AST_REQ_CLEARS_WORD:
        assert property (ce_i && !reset_request_input_n_i |=> !st_r.word_seen)
        else $error("reset request did not clear written word flag");

    AST_FINE_GAIN_STEP:
        assert property (ce_i && st_r.data[1] == 16'h8000 && st_r.offs[1] == '0 &&
                         !st_r.gnd_en
                         |=> `DTC_CODE_W'(channel_code_o[1] + 21'h040000) ==
                         `DTC_CODE_W'(-(`DTC_CODE_W'(signed'($past(st_r.fine[1]))) <<< 2)))
        else $error("fine gain trim not applied at negative full scale");

    AST_RANGE_WRITE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_RANGE_A &&
                         reg_req_i.wdata[`DTC_RANGE_W-1:0] != `DTC_RANGE_RSVD |=>
                         range_sel_o[0] == $past(reg_req_i.wdata[`DTC_RANGE_W-1:0]))
        else $error("range write not applied");

    AST_RANGE_RSVD_REFUSED:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_RANGE_B &&
                         reg_req_i.wdata[`DTC_RANGE_W-1:0] == `DTC_RANGE_RSVD |=>
                         $stable(range_sel_o[1]) && range_sel_o[1] != `DTC_RANGE_RSVD)
        else $error("reserved range code accepted");

    AST_FINE_WRITE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_FINE_B |=>
                         st_r.fine[1] == $past(reg_req_i.wdata[`DTC_FINE_W-1:0]))
        else $error("fine gain write not applied");

    AST_OFFSET_WRITE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_OFFS_A |=>
                         st_r.offs[0] == $past(reg_req_i.wdata[`DTC_OFFS_W-1:0]))
        else $error("offset trim write not applied");

    AST_DATA_WRITE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_DATA_B |=>
                         st_r.data[1] == $past(reg_req_i.wdata))
        else $error("data write not applied");

    AST_DIR_WRITE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_FUNC |=>
                         io_pin_zero_oe_n_o == !$past(reg_req_i.wdata[`DTC_FUNC_D0_DIR]))
        else $error("io direction write not applied");

    AST_OUTPUT_VALUE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_FUNC &&
                         reg_req_i.wdata[`DTC_FUNC_D1_DIR] |=>
                         io_pin_one_o == $past(reg_req_i.wdata[`DTC_FUNC_D1_VAL]))
        else $error("output pin value not driven");

    AST_GND_EN_WRITE:
        assert property (ce_i && reg_req_i.wr && reg_req_i.addr == `DTC_ADDR_FUNC |=>
                         local_gnd_adjust_en_o == $past(reg_req_i.wdata[`DTC_FUNC_GND_EN]))
        else $error("ground offset enable write not applied");

    AST_STATUS_READ:
        assert property (ce_i && reg_req_i.rd && reg_req_i.addr == `DTC_ADDR_STATUS |=>
                         reg_rdata_o[`DTC_STAT_MON] == $past(supply_monitor_output_o))
        else $error("status read does not show supply monitor");

    AST_RDATA_IDLE:
        assert property (ce_i && !reg_req_i.rd |=> reg_rdata_o == '0)
        else $error("read data not cleared outside a read");

    AST_FREEZE:
        assert property (!ce_i |=> $stable(supply_monitor_output_o) &&
                         $stable(channel_code_o) && $stable(output_clamp_gate_o))
        else $error("state moved while clock enable low");
endmodule

// File: core/dac_trim_params.svh
// constants for the dac trim and output control block
`ifndef DAC_TRIM_PARAMS_SVH
`define DAC_TRIM_PARAMS_SVH
`define DTC_ADDR_W       4
`define DTC_DATA_W       16
`define DTC_CODE_W       21
`define DTC_OFFS_W       8
`define DTC_FINE_W       6
`define DTC_RANGE_W      2
`define DTC_GND_W        8
`define DTC_FRAC_BITS    3
`define DTC_GAIN_SHIFT   13
`define DTC_ADDR_DATA_A  4'h0
`define DTC_ADDR_DATA_B  4'h1
`define DTC_ADDR_RANGE_A 4'h2
`define DTC_ADDR_RANGE_B 4'h3
`define DTC_ADDR_FINE_A  4'h4
`define DTC_ADDR_FINE_B  4'h5
`define DTC_ADDR_OFFS_A  4'h6
`define DTC_ADDR_OFFS_B  4'h7
`define DTC_ADDR_FUNC    4'h8
`define DTC_ADDR_STATUS  4'h9
`define DTC_FUNC_D0_VAL  1
`define DTC_FUNC_D0_DIR  2
`define DTC_FUNC_D1_VAL  3
`define DTC_FUNC_D1_DIR  4
`define DTC_FUNC_GND_EN  5
`define DTC_STAT_MON     0
`define DTC_STAT_REQ     1
`define DTC_STAT_WORD    2
`define DTC_STAT_OPEN    3
`define DTC_RANGE_10V    2'h0
`define DTC_RANGE_10V25  2'h1
`define DTC_RANGE_10V5   2'h2
`define DTC_RANGE_RSVD   2'h3
`define DTC_RST_DATA     16'h0000
`define DTC_RST_OFFS     8'h00
`define DTC_RST_FINE     6'h00
`define DTC_RST_DIR      2'h0
`define DTC_RST_VAL      2'h0
`endif

// File: core/dac_trim_pkg.sv
// types for the dac trim and output control block
package dac_trim_pkg;
    typedef enum logic {CLAMP_HOLD, CLAMP_OPEN} clamp_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [1:0][15:0] data;
        logic [1:0][1:0]  range;
        logic [1:0][5:0]  fine;
        logic [1:0][7:0]  offs;
        logic             gnd_en;
        logic [1:0]       io_dir;
        logic [1:0]       io_val;
        logic             word_seen;
        clamp_state_t     clamp;
        logic             supply_mon;
        logic [15:0]      rdata;
        logic [1:0][20:0] code;
    } trim_state_t;
endpackage

// File: verif/host_side_model.sv
// far side model: supply supervisor and external io switches
`timescale 1ns/1ps
module host_side_model (
    input  wire logic       supply_good_i,
    input  wire logic       hold_req_i,
    input  wire logic [1:0] ext_level_i,
    input  wire logic [1:0] drv_val_i,
    input  wire logic [1:0] oe_n_i,
    output logic            supply_ok_o,
    output logic            reset_request_n_o,
    output logic [1:0]      pin_level_o
);
    assign supply_ok_o       = supply_good_i;
    // supervisor pulls the request low on brownout or on command
    assign reset_request_n_o = supply_good_i & ~hold_req_i;
    // a driven pin shows the device value, else the external switch
    assign pin_level_o[0]    = oe_n_i[0] ? ext_level_i[0] : drv_val_i[0];
    assign pin_level_o[1]    = oe_n_i[1] ? ext_level_i[1] : drv_val_i[1];
endmodule

// File: verif/test_dac_trim_and_output_control.sv
// self-checking bench for the dac trim and output control block
`timescale 1ns/1ps
`include "dac_trim_params.svh"
module test_dac_trim_and_output_control;
    logic                   clk_sys_i, rstn_i, sup_good, hold_req, sup_ok, rst_n, mon, gnd_en;
    dac_trim_pkg::reg_req_t req;
    logic [15:0]            rdata, rv;
    logic [1:0]             amp, clamp, ext, pin, drv, oe_n;
    logic [1:0][20:0]       code;
    logic [1:0][1:0]        rng;
    logic [1:0][7:0]        gnd;
    logic [15:0]            m_data [2];
    logic [7:0]             m_offs [2];
    logic [5:0]             m_fine [2];
    logic [1:0]             m_rng [2];
    logic [1:0]             m_dir, m_val;
    logic                   ce;
    logic                   m_gnd;
    int                     miscompares, check_count, seed, i;

    dac_trim_ctrl dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce), .reg_req_i(req),
        .reg_rdata_o(rdata), .supply_ok_i(sup_ok), .reset_request_input_n_i(rst_n),
        .supply_monitor_output_o(mon), .amp_connect_gate_o(amp), .output_clamp_gate_o(clamp),
        .channel_code_o(code), .range_sel_o(rng), .local_gnd_adjust_en_o(gnd_en),
        .gnd_diff_i(gnd), .io_pin_zero_i(pin[0]), .io_pin_zero_o(drv[0]),
        .io_pin_zero_oe_n_o(oe_n[0]), .io_pin_one_i(pin[1]), .io_pin_one_o(drv[1]),
        .io_pin_one_oe_n_o(oe_n[1]));
    host_side_model partner (.supply_good_i(sup_good), .hold_req_i(hold_req),
        .ext_level_i(ext), .drv_val_i(drv), .oe_n_i(oe_n), .supply_ok_o(sup_ok),
        .reset_request_n_o(rst_n), .pin_level_o(pin));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bus write, model follows the same write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
        if (a <= 4'h1) m_data[a[0]] = d;
        if (a[3:1] == 3'h1 && d[1:0] != 2'h3) m_rng[a[0]] = d[1:0];
        if (a[3:1] == 3'h2) m_fine[a[0]] = d[5:0];
        if (a[3:1] == 3'h3) m_offs[a[0]] = d[7:0];
        if (a == `DTC_ADDR_FUNC) begin
            m_gnd = d[5];
            m_dir = {d[4], d[2]};
            if (d[2]) m_val[0] = d[1];
            if (d[4]) m_val[1] = d[3];
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata;
    endtask

    function automatic logic [20:0] exp_code(input int ch);
        int d, e;
        d = $signed(m_data[ch]);
        e = d * 8 + $signed(m_offs[ch]) + ((d * $signed(m_fine[ch])) >>> 13);
        if (m_gnd) e += $signed(gnd[ch]);
        return e[20:0];
    endfunction

    task automatic settle;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    initial begin
        #2ms;
        miscompares++;
        end_sim();
    end

    initial begin
        req = '0;
        ce = 1'b1;
        rstn_i = 1'b0;
        sup_good = 1'b0;
        hold_req = 1'b0;
        ext = 2'h0;
        gnd = '0;
        seed = 60;
        m_data = '{16'h0000, 16'h0000};
        m_offs = '{8'h00, 8'h00};
        m_fine = '{6'h00, 6'h00};
        m_rng = '{2'h0, 2'h0};
        {m_dir, m_val, m_gnd} = '0;
        repeat (3) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(negedge clk_sys_i);
        chk("clamp", {clamp, amp}, 4'hc);
        chk("oe_n", oe_n, 2'h3);
        chk("gnd_en", gnd_en, 1'b0);
        wr(`DTC_ADDR_DATA_A, 16'h1234);
        settle();
        chk("clamp", {clamp, amp}, 4'hc);
        @(posedge clk_sys_i);
        sup_good <= 1'b1;
        settle();
        chk("monitor", mon, 1'b1);
        chk("clamp", {clamp, amp}, 4'hc);
        wr(`DTC_ADDR_DATA_A, 16'h0000);
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("clamp", {clamp, amp}, 4'h3);
        rd(`DTC_ADDR_STATUS, rv);
        chk("status", rv, 16'h000f);
        rd(4'ha, rv);
        chk("unmapped", rv, 16'h0000);
        wr(`DTC_ADDR_OFFS_A, 16'h00f0);
        wr(`DTC_ADDR_DATA_B, 16'h8000);
        settle();
        chk("code a", code[0], 21'h1ffff0);
        chk("code b", code[1], 21'h1c0000);
        @(posedge clk_sys_i);
        hold_req <= 1'b1;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("clamp", {clamp, amp}, 4'hc);
        @(posedge clk_sys_i);
        hold_req <= 1'b0;
        settle();
        chk("clamp", {clamp, amp}, 4'hc);
        wr(`DTC_ADDR_DATA_B, 16'h8000);
        settle();
        chk("clamp", {clamp, amp}, 4'h3);
        @(posedge clk_sys_i);
        sup_good <= 1'b0;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("clamp", {clamp, amp, mon}, 5'h18);
        @(posedge clk_sys_i);
        ce <= 1'b0;
        sup_good <= 1'b1;
        settle();
        chk("frozen", {clamp, mon}, 3'h6);
        @(posedge clk_sys_i);
        ce <= 1'b1;
        settle();
        chk("monitor", mon, 1'b1);
        $display("test clamp done");
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys_i);
            gnd <= 16'($random(seed));
            ext <= 2'($random(seed));
            wr({3'h0, i[0]}, 16'($random(seed)));
            wr({3'h1, i[0]}, 16'($random(seed)));
            wr({3'h2, i[0]}, 16'($random(seed)));
            wr({3'h3, i[0]}, 16'($random(seed)));
            wr(`DTC_ADDR_FUNC, 16'($random(seed)));
            settle();
            chk("code a", code[0], exp_code(0));
            chk("code b", code[1], exp_code(1));
            chk("range", {rng[1], rng[0]}, {m_rng[1], m_rng[0]});
            chk("gnd_en", gnd_en, m_gnd);
            chk("io out", {oe_n, drv}, {~m_dir, m_val});
            rd(`DTC_ADDR_FUNC, rv);
            chk("func", rv, {10'h000, m_gnd, m_dir[1], m_dir[1] ? m_val[1] : ext[1],
                m_dir[0], m_dir[0] ? m_val[0] : ext[0], 1'b0});
        end
        $display("test trim and io done");
        end_sim();
    end
endmodule
